// >>> i2csp_top.sv
// Serial slave port giving a bus master access to an 8-bit register space.
// Assumes pull-ups on both bus lines and pins from outside this clock.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// R1: Slave only, up to 1000 kHz bus
// R2: Address from straps: 5A/5B, or 58/59
// R3: Data changes only while clock is low
// R4: Master alone makes start and stop
// R5: Repeated start acts as a fresh start
// R6: Nine clocks per byte, MSB first, ack
// R7: First byte is address plus direction
// R8: No limit on transaction length
// R9: Device acks every write byte
// R10: Register address follows the address byte
// R11: Pointer increments after each written byte
// R12: Read follows a pointer write, then restart
// R13: Read streams from pointer, incrementing
// R14: Data pin only pulled low; clock input
// R15: Master idles released, ends with stop
// R16: Foreign address: no ack, ignore traffic
// R17: Master nack ends read, device releases
module i2csp_top
  import i2csp_pkg::*;
#(
  parameter int AW = 8
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // Address straps
  input wire logic addr_strap,
  input wire logic addr_strap_upper,
  // Register write strobe for the device core
  output logic wr_strobe,
  output logic [7:0] wr_addr,
  output logic [7:0] wr_data
);

  // Elaboration check: register space is byte addressed here
  if (AW != 8)
  begin : g_bad_aw
    $error("AW must be 8");
  end
  if (MIN_PHASE_CYC < 4)
  begin : g_bad_rate
    $error("clock too slow for the bus rate");
  end

  // Synchronisers (first stage read only by second)
  logic [1:0] scl_sync_reg;
  logic [1:0] sda_sync_reg;
  logic scl_d_reg;
  logic sda_d_reg;
  logic strap_reg;
  logic strap_up_reg;
  logic [1:0] strap_sync_reg;
  logic [1:0] strap_up_sync_reg;

  // Protocol state
  i2csp_state_t state_reg, state_next;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] ptr_reg;
  logic ack_due_reg;
  logic data_byte_reg;
  logic ack_phase_reg;
  logic drive_low_reg;
  logic master_nack_reg;
  logic [7:0] rdata;
  logic wr_strobe_reg;
  logic [7:0] wr_addr_reg;
  logic [7:0] wr_data_reg;

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      scl_d_reg <= 1'h1;
      sda_d_reg <= 1'h1;
    end
    else
    begin
      scl_sync_reg <= {scl_sync_reg[0], scl_in};
      sda_sync_reg <= {sda_sync_reg[0], sda_in};
      scl_d_reg <= scl_sync_reg[1];
      sda_d_reg <= sda_sync_reg[1];
    end
  end

  // Straps sampled every cycle, in reset too, so no port feeds a reset value
  always_ff @(posedge clock)
  begin
    strap_sync_reg <= {strap_sync_reg[0], addr_strap};
    strap_up_sync_reg <= {strap_up_sync_reg[0], addr_strap_upper};
    strap_reg <= strap_sync_reg[1];
    strap_up_reg <= strap_up_sync_reg[1];
  end

  // Edge and condition decode on the synchronised lines
  wire scl_now = scl_sync_reg[1];
  wire sda_now = sda_sync_reg[1];
  wire scl_rise = scl_now & ~scl_d_reg;
  wire scl_fall = ~scl_now & scl_d_reg;
  wire start_cond = scl_now & scl_d_reg & sda_d_reg & ~sda_now; // see R4
  wire stop_cond = scl_now & scl_d_reg & ~sda_d_reg & sda_now;

  // Strapped address selection
  function automatic logic [6:0] own_addr(input logic s, input logic su);
    case ({su, s})
      2'b00: own_addr = ADDR_LOW_LOW;
      2'b01: own_addr = ADDR_LOW_HIGH;
      2'b10: own_addr = ADDR_UP_LOW;
      default: own_addr = ADDR_UP_HIGH;
    endcase
  endfunction

  wire [6:0] my_addr = own_addr(strap_reg, strap_up_reg); // see R2
  wire [7:0] byte_in = {shift_reg[6:0], sda_now};
  wire byte_done = scl_rise & ~ack_phase_reg & (bit_cnt_reg == 4'h7);
  wire addr_match = (byte_in[7:1] == my_addr); // see R16
  wire ack_enter = scl_fall & ~ack_phase_reg & (bit_cnt_reg == 4'h8);
  wire ack_end = scl_fall & ack_phase_reg;
  // Who owns the coming ack slot, and whether the byte moves the pointer
  wire ack_drive = (state_reg == ST_DEVADDR && addr_match) ||
                   state_reg == ST_REGADDR || state_reg == ST_WDATA;
  wire data_byte = (state_reg == ST_WDATA) || (state_reg == ST_RDATA);

  // Next-state decode; start wins over every phase, even mid-byte
  always_comb
  begin
    state_next = state_reg;
    if (start_cond)
    begin
      state_next = ST_DEVADDR; // see R5
    end
    else if (stop_cond)
    begin
      state_next = ST_IDLE; // see R15
    end
    else if (byte_done)
    begin
      case (state_reg)
        ST_DEVADDR:
        begin
          if (!addr_match)
            state_next = ST_IGNORE; // see R16
          else if (byte_in[0])
            state_next = ST_RDATA; // see R7
          else
            state_next = ST_REGADDR; // see R10
        end
        ST_REGADDR: state_next = ST_WDATA;
        default: state_next = state_reg;
      endcase
    end
    else if (ack_end && state_reg == ST_RDATA && master_nack_reg)
    begin
      state_next = ST_IGNORE; // see R17
    end
  end

  // Bit counter and ack phase flag, nine clocks per unit
  always_ff @(posedge clock)
  begin
    if (rst || start_cond || stop_cond)
    begin
      bit_cnt_reg <= 4'h0;
      ack_phase_reg <= 1'b0;
    end
    else if (scl_rise && !ack_phase_reg)
    begin
      bit_cnt_reg <= bit_cnt_reg + 4'h1; // see R6
    end
    else if (ack_enter)
    begin
      // Ack slot opens only once the eighth bit's clock has fallen
      ack_phase_reg <= 1'b1;
    end
    else if (ack_end)
    begin
      bit_cnt_reg <= 4'h0;
      ack_phase_reg <= 1'b0;
    end
  end

  // Shift in MSB first on each rising clock of the eight data bits
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      shift_reg <= 8'h00;
    end
    else if (scl_rise && !ack_phase_reg)
    begin
      shift_reg <= byte_in; // see R6
    end
  end

  // State, direction and master acknowledge capture
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state_reg <= ST_IDLE;
      ack_due_reg <= 1'b0;
      data_byte_reg <= 1'b0;
      master_nack_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      if (byte_done)
      begin
        ack_due_reg <= ack_drive; // see R9, R16
        data_byte_reg <= data_byte;
      end
      if (scl_rise && ack_phase_reg)
        master_nack_reg <= sda_now; // see R17
    end
  end

  // Pointer: loaded by the register address, bumped at each data byte's
  // ack sample so the next read byte is fetched before the slot closes
  // No upper bound; the pointer simply wraps, so length is unlimited
  wire wr_byte = byte_done && state_reg == ST_WDATA;
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      ptr_reg <= PTR_RESET;
    end
    else if (byte_done && state_reg == ST_REGADDR)
    begin
      ptr_reg <= byte_in;
    end
    else if (scl_rise && ack_phase_reg && data_byte_reg)
    begin
      ptr_reg <= ptr_reg + 8'h01; // see R11, R8, R13
    end
  end

  // Register write strobe toward the device core
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      wr_strobe_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      wr_data_reg <= 8'h00;
    end
    else
    begin
      wr_strobe_reg <= wr_byte; // see R11
      if (wr_byte)
      begin
        wr_addr_reg <= ptr_reg;
        wr_data_reg <= byte_in;
      end
    end
  end

  // Local copy of written registers feeds reads
  i2csp_regmem #(
    .AW(AW),
    .DW(BYTE_W)
  ) u_mem (
    .clock(clock),
    .we(wr_strobe_reg),
    .waddr(wr_addr_reg),
    .wdata(wr_data_reg),
    .raddr(ptr_reg),
    .rdata(rdata)
  );

  // Data pin drive, changed only on falling clock so it is stable when high
  // A master nack leaves the line free so the master can stop
  wire [2:0] bit_idx = LAST_BIT - bit_cnt_reg[2:0];
  wire send_next = (state_reg == ST_RDATA) && !master_nack_reg;
  always_ff @(posedge clock)
  begin
    if (rst || start_cond || stop_cond)
    begin
      drive_low_reg <= 1'b0;
    end
    else if (scl_fall)
    begin
      if (ack_enter)
        drive_low_reg <= ack_due_reg; // see R9, R3
      else if (ack_end)
        drive_low_reg <= send_next && !rdata[LAST_BIT]; // see R13, R17
      else if (state_reg == ST_RDATA)
        drive_low_reg <= ~rdata[bit_idx]; // see R6
      else
        drive_low_reg <= 1'b0;
    end
  end

  // Open drain: value flop held low, enable active low while pulling
  always_ff @(posedge clock)
  begin
    sda_out <= 1'b0; // see R14
    if (rst)
      sda_oe_n <= 1'b1;
    else
      sda_oe_n <= ~drive_low_reg; // see R14, R1
  end

  assign wr_strobe = wr_strobe_reg;
  assign wr_addr = wr_addr_reg;
  assign wr_data = wr_data_reg;

endmodule
`default_nettype wire

// >>> i2csp_pkg.sv
// Package for the serial slave register port: addresses, timing, types.
// Assumes a single 100 MHz clock domain in the user of this package.
package i2csp_pkg;

  // Strapped 7-bit slave addresses
  localparam logic [6:0] ADDR_LOW_LOW = 7'h5a;
  localparam logic [6:0] ADDR_LOW_HIGH = 7'h5b;
  localparam logic [6:0] ADDR_UP_LOW = 7'h58;
  localparam logic [6:0] ADDR_UP_HIGH = 7'h59;

  // Bus rates served and the system clock rate
  localparam int CLK_HZ = 100000000;
  localparam int FAST_HZ = 400000;
  localparam int FAST_PLUS_HZ = 1000000;
  // Fewest system cycles in one bus clock phase at the fastest rate
  localparam int MIN_PHASE_CYC = CLK_HZ / FAST_PLUS_HZ / 2;

  // Byte layout
  localparam int BYTE_W = 8;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [7:0] PTR_RESET = 8'h00;

  // Register file access as seen by the user side
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] data;
  } i2csp_wr_t;

  // Transaction phases
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DEVADDR,
    ST_REGADDR,
    ST_WDATA,
    ST_RDATA,
    ST_IGNORE
  } i2csp_state_t;

endpackage

// >>> i2csp_regmem.sv
// Small register memory reached by the serial port.
// Assumes one clock; read data come out of a register one cycle later.
`timescale 1ns/1ps
`default_nettype none
module i2csp_regmem
  import i2csp_pkg::*;
#(
  parameter int AW = 8,
  parameter int DW = 8
)
(
  // Clock
  input wire logic clock,
  // Write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  // Read port
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  // Plain synchronous RAM; contents are not reset
  always_ff @(posedge clock)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule
`default_nettype wire

// >>> i2csp_assertions.sv
// Checker for the serial port pins and the write strobe.
// Assumes it sees the raw bus pins, as the design does.
`timescale 1ns/1ps
`default_nettype none
module i2csp_assertions (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Bus
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  // Strobe
  input wire logic wr_strobe,
  input wire logic [7:0] wr_addr
);
  logic sda_d_reg;
  logic seq_reg;
  logic [7:0] last_reg;
  default clocking dc @(posedge clock); endclocking
  default disable iff (rst);
  // A start ends a run of strobes, so the first byte is never compared
  always_ff @(posedge clock)
  begin
    sda_d_reg <= sda_in;
    seq_reg <= !(rst || (scl_in && sda_d_reg && !sda_in)) &&
      (seq_reg || wr_strobe);
    if (wr_strobe)
      last_reg <= wr_addr;
  end
  out_low_a: assert property (!sda_out)
    else $error("data driven high");
  reset_idle_a: assert property (disable iff (1'b0)
    rst |=> sda_oe_n && !wr_strobe) else $error("busy after reset");
  pull_low_a: assert property ($fell(sda_oe_n) |-> !scl_in)
    else $error("pull in clock high");
  drive_hold_a: assert property (scl_in && $past(scl_in) |->
    $stable(sda_oe_n)) else $error("drive moved in high");
  strobe_pulse_a: assert property (wr_strobe |=> !wr_strobe)
    else $error("strobe too long");
  ptr_step_a: assert property (wr_strobe && seq_reg |->
    wr_addr == last_reg + 8'h01) else $error("pointer skipped");
  write_ack_a: assert property (wr_strobe |-> ##[1:24] !sda_oe_n)
    else $error("no ack");
  stop_free_a: assert property (scl_in && $rose(sda_in) |=>
    sda_oe_n [*8]) else $error("held after stop");
endmodule
`default_nettype wire

// >>> i2csp_host.sv
// Bus master model: drives the bus clock and pulls the data line.
// Assumes the bench resolves data with a pull-up.
`timescale 1ns/1ps
`default_nettype none
module i2csp_host (
  // Clock
  input wire logic clock,
  // Bus
  input wire logic sda,
  output logic scl,
  output logic sda_oe_n
);
  // Both lines released while idle
  initial
  begin
    scl = 1'b1;
    sda_oe_n = 1'b1;
  end
  // A quarter of the 160 ns bus period
  task automatic w4;
    repeat (4) @(negedge clock);
  endtask
  // Data falls while clock is high; serves as repeated start too
  task automatic start;
    sda_oe_n = 1'b1;
    w4();
    scl = 1'b1;
    w4();
    sda_oe_n = 1'b0;
    w4();
    scl = 1'b0;
    w4();
  endtask
  // Data rises while clock is high
  task automatic stop;
    sda_oe_n = 1'b0;
    w4();
    scl = 1'b1;
    w4();
    sda_oe_n = 1'b1;
    w4();
  endtask
  // Eight bits MSB first, then the ack slot; data moves only in low
  task automatic xfer(input logic [7:0] tx, input logic ack_in,
    output logic [7:0] rx, output logic ack);
    for (int i = 8; i >= 0; i--)
    begin
      sda_oe_n = (i == 0) ? ack_in : tx[i-1];
      w4();
      scl = 1'b1;
      w4();
      if (i > 0)
        rx[i-1] = sda;
      else
        ack = sda;
      w4();
      scl = 1'b0;
      w4();
    end
  endtask
endmodule
`default_nettype wire

// >>> tb_top.sv
// Bench for the serial slave port: strap table, writes, reads.
// Assumes the host model and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clock, rst, strap_lo, strap_up, scl, host_oe_n;
  logic sda_out, sda_oe_n, wr_strobe;
  logic [7:0] wr_addr, wr_data, ra;
  logic [6:0] dev;
  logic [7:0] mem [256];
  logic [15:0] got_q [$];
  wire logic sda_line;
  int num_errors = 0, n_checks = 0, seed = 56621;
  // Pull-up: low when either side pulls
  assign sda_line = host_oe_n & (sda_oe_n | sda_out);
  i2csp_top i_i2csp_top (.clock(clock), .rst(rst), .scl_in(scl),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .addr_strap(strap_lo), .addr_strap_upper(strap_up),
    .wr_strobe(wr_strobe), .wr_addr(wr_addr), .wr_data(wr_data));
  i2csp_host i_i2csp_host (.clock(clock), .sda(sda_line), .scl(scl),
    .sda_oe_n(host_oe_n));
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Log strobes; each byte's entry lands before its ack slot ends
  always @(negedge clock)
    if (wr_strobe === 1'b1)
      got_q.push_back({wr_addr, wr_data});
  task automatic check(input string what, input logic [15:0] got, exp);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  // Strap table: the address the port should answer on
  function automatic logic [6:0] exp_addr(input logic up, lo);
    return up ? (lo ? 7'h59 : 7'h58) : (lo ? 7'h5b : 7'h5a);
  endfunction
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wr_txn(input logic [6:0] d7, input int n,
    input logic ok);
    logic [7:0] rx, d;
    logic ack;
    i_i2csp_host.start();
    i_i2csp_host.xfer({d7, 1'b0}, 1'b1, rx, ack);
    check("dev ack", ack, !ok);
    i_i2csp_host.xfer(ra, 1'b1, rx, ack);
    check("reg ack", ack, !ok);
    for (int i = 0; i < n; i++)
    begin
      d = 8'($random(seed));
      i_i2csp_host.xfer(d, 1'b1, rx, ack);
      check("data ack", ack, !ok);
      if (ok)
      begin
        mem[ra + 8'(i)] = d;
        check("strobe", got_q.pop_front(), {ra + 8'(i), d});
      end
    end
    i_i2csp_host.stop();
    check("spare strobes", got_q.size(), 0);
  endtask
  task automatic rd_txn(input int n, input logic sep);
    logic [7:0] rx;
    logic ack;
    i_i2csp_host.start();
    i_i2csp_host.xfer({dev, 1'b0}, 1'b1, rx, ack);
    i_i2csp_host.xfer(ra, 1'b1, rx, ack);
    if (sep)
      i_i2csp_host.stop();
    i_i2csp_host.start();
    i_i2csp_host.xfer({dev, 1'b1}, 1'b1, rx, ack);
    check("read ack", ack, 0);
    for (int i = 0; i < n; i++)
    begin
      i_i2csp_host.xfer(8'hff, i == n - 1, rx, ack);
      check("read data", rx, mem[ra + 8'(i)]);
    end
    i_i2csp_host.stop();
    check("bus released", sda_line, 1);
  endtask
  // Every strap setting; the first case wraps the pointer past 0xff
  initial
  begin
    rst = 1'b1;
    {strap_up, strap_lo} = 2'h0;
    repeat (6) @(negedge clock);
    rst = 1'b0;
    for (int k = 0; k < 4; k++)
    begin
      {strap_up, strap_lo} = 2'(k);
      repeat (8) @(negedge clock);
      dev = exp_addr(strap_up, strap_lo);
      ra = (k == 0) ? 8'hfe : 8'($random(seed));
      wr_txn(dev ^ 7'h01, 2, 1'b0);
      wr_txn(dev, 4, 1'b1);
      rd_txn(4, 1'(k));
      $display("strap case %0d done", k);
    end
    finish_test();
  end
  // Watchdog: about three times the length of the full run
  initial
  begin
    #300000;
    num_errors++;
    finish_test();
  end
endmodule
bind i2csp_top i2csp_assertions i_i2csp_assertions (.clock(clock),
  .rst(rst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe_n(sda_oe_n), .wr_strobe(wr_strobe), .wr_addr(wr_addr));
`default_nettype wire
